// >>> inc/sra_pkg.sv
// constants, field layouts and carrier types for the serial rom access block
// assumes a 32-bit apb slave port and a three-wire serial rom on a slower link clock
package sra_pkg;

    localparam logic [7:0] SRA_CTRL_OFF    = 8'h1c;
    localparam logic [7:0] SRA_STAT_OFF    = 8'h20;
    localparam logic [7:0] SRA_ADDR_LO_OFF = 8'h24;
    localparam logic [7:0] SRA_ADDR_HI_OFF = 8'h28;

    localparam int SRA_CS_BIT  = 0;
    localparam int SRA_CLK_BIT = 1;
    localparam int SRA_DI_BIT  = 2;
    localparam int SRA_DO_BIT  = 3;
    localparam int SRA_EN_BIT  = 4;

    localparam logic [7:0] SRA_CTRL_RST  = 8'h00;
    localparam logic [7:0] SRA_CTRL_WMSK = 8'h17;

    localparam logic [2:0] SRA_CMD_READ   = 3'h6;
    localparam int         SRA_CMD_BITS   = 3;
    localparam int         SRA_ADDR_SMALL = 6;
    localparam int         SRA_ADDR_LARGE = 8;
    localparam int         SRA_DATA_BITS  = 16;
    localparam logic [1:0] SRA_LAST_WORD  = 2'h3;

    // each serial clock phase lasts at least this long on the link clock
    localparam int SRA_PHASE_NS   = 250;
    localparam int SRA_LINK_NS    = 160;
    localparam int SRA_PHASE_CYC  = (SRA_PHASE_NS + SRA_LINK_NS - 1) / SRA_LINK_NS;

    typedef struct packed {
        logic di;
        logic sclk;
        logic cs;
    } sra_pins_t;

    typedef struct packed {
        logic tx_fifo_level_enable;
        logic config_a_bit5;
        logic external_phy_select;
        logic error_frame_accept_n;
        logic slow_buffer_timing;
        logic buffer_width_select;
        logic scrambler_bypass;
    } sra_cfg_t;

    typedef enum logic [2:0] {
        AL_IDLE,
        AL_SELECT,
        AL_SHIFT,
        AL_DESELECT,
        AL_DONE
    } sra_al_state_t;

endpackage : sra_pkg

// >>> sim/serial_rom_access_test.sv
// self-checking bench for the serial rom access block over apb
// assumes the rom model beside it and a free running link clock
`timescale 1ns/10ps
module serial_rom_access_test
    import sra_pkg::*;
;
    logic        clk_sys, clk_link, rst, psel, penable, pwrite, pready, pslverr;
    logic        hw_pin, size_sel, cs, sck, di, dout, done, viol, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [47:0] sta, exp_sta;
    logic [15:0] w;
    sra_cfg_t    cfg;
    int          errors, n_tests;

    sra_top uut (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_link(clk_link),
        .hardware_reset_pin(hw_pin), .rom_size_select(size_sel),
        .rom_data_out(dout), .rom_chip_select(cs), .rom_serial_clock(sck),
        .rom_data_in(di), .station_address(sta), .config_a_byte(cfg),
        .autoload_done(done));

    sra_rom_model rom (.cs(cs), .sclk(sck), .di(di), .size_small(size_sel),
        .do_bit(dout), .viol(viol));

    function automatic logic [7:0] rb(input logic [7:0] b);
        return {b[3:0], ~b[3:0]};
    endfunction : rb

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task end_sim;
        $display("errors %0d of %0d checks", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // control write, then rom settling time before anything else moves
    task automatic wc(input logic [7:0] d);
        apb(1'b1, SRA_CTRL_OFF, {24'h0, d});
        repeat (3) @(posedge clk_link);
    endtask : wc

    task automatic shift_bit(input logic b);
        wc({5'h02, b, 2'h1});
        wc({5'h02, b, 2'h3});
        chk({di, sck, cs}, {b, 2'h3});
        wc({5'h02, b, 2'h1});
    endtask : shift_bit

    task automatic sw_read(input logic [7:0] a, input int nab);
        wc(8'h00);
        wc(8'h11);
        for (int i = 2; i >= 0; i--) shift_bit(SRA_CMD_READ[i]);
        for (int i = nab - 1; i >= 0; i--) shift_bit(a[i]);
        for (int i = 15; i >= 0; i--)
        begin
            wc(8'h13);
            apb(1'b0, SRA_CTRL_OFF, 32'h0);
            w[i] = r[SRA_DO_BIT];
            wc(8'h11);
        end
        wc(8'h00);
        chk(w, {rb({a[6:0], 1'b1}), rb({a[6:0], 1'b0})});
    endtask : sw_read

    initial
    begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    initial
    begin
        clk_link = 1'b0;
        #37;
        forever #80 clk_link = ~clk_link;
    end

    initial
    begin
        #400000;
        errors++;
        end_sim();
    end

    initial
    begin
        errors = 0;
        n_tests = 0;
        rst = 1'b1;
        hw_pin = 1'b0;
        size_sel = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_link);
        @(posedge clk_sys);
        hw_pin <= 1'b1;
        chk(done, 1'b0);
        // software tries to take the pins while the sequencer runs
        wc(8'h10);
        for (int i = 0; i < 40000 && done !== 1'b1; i++) @(posedge clk_sys);
        for (int i = 0; i < 6; i++) exp_sta[8*i+:8] = rb(8'(i));
        chk(sta, exp_sta);
        chk(cfg, rb(8'h06) & 8'h7f);
        apb(1'b0, SRA_STAT_OFF, 32'h0);
        chk(r, 32'h2);
        apb(1'b0, SRA_ADDR_LO_OFF, 32'h0);
        chk(r, exp_sta[31:0]);
        // no second run once done: chip select stays low
        for (int i = 0; i < 40; i++)
        begin
            @(negedge clk_link);
            chk(cs, 1'b0);
        end
        chk(cs, 1'b0);
        apb(1'b0, 8'h2c, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        wc(8'h07);
        chk({di, sck, cs}, 3'h0);
        wc(8'h11);
        apb(1'b0, SRA_CTRL_OFF, 32'h0);
        chk(r, 32'h19);
        wc(8'h00);
        apb(1'b0, SRA_CTRL_OFF, 32'h0);
        chk(r, 32'h0);
        wc(8'h15);
        chk({di, sck, cs}, 3'h5);
        size_sel <= 1'b0;
        sw_read(8'h84, 8);
        size_sel <= 1'b1;
        sw_read(8'h25, 6);
        chk(viol, 1'b0);
        end_sim();
    end
endmodule : serial_rom_access_test

// >>> sim/sra_rom_model.sv
// behavioural three-wire serial rom used as the far side of the access block
// assumes word addressing, one word per address, data shifted msb first
`timescale 1ns/10ps
module sra_rom_model (
    input  wire logic cs,
    input  wire logic sclk,
    input  wire logic di,
    input  wire logic size_small,
    output logic      do_bit,
    output logic      viol
);
    int         cnt;
    int         nab;
    logic [7:0] sr;
    logic [7:0] addr;
    logic [2:0] cmd;
    logic [15:0] w;
    realtime    t_rise;

    function automatic logic [7:0] rom_byte(input logic [7:0] b);
        return {b[3:0], ~b[3:0]};
    endfunction : rom_byte

    initial
    begin
        do_bit = 1'b0;
        viol   = 1'b0;
        cnt    = 0;
        t_rise = 0;
    end

    // ready level while selected and idle
    always @(posedge cs)
    begin
        cnt    = 0;
        do_bit = 1'b1;
    end

    // released line shows the inverse of its last level
    always @(negedge cs) do_bit = ~do_bit;

    always @(posedge sclk)
    begin
        if (cs === 1'b1)
        begin
            cnt    = cnt + 1;
            sr     = {sr[6:0], di};
            t_rise = $realtime;
            nab    = size_small ? 6 : 8;
            if (cnt == 3)
                cmd = sr[2:0];
            if (cnt == 3 + nab)
                addr = size_small ? {2'h0, sr[5:0]} : sr;
            w = {rom_byte({addr[6:0], 1'b1}), rom_byte({addr[6:0], 1'b0})};
            // only a read command gets data, one bit per rising clock
            if (cnt > 3 + nab && cnt <= 19 + nab && cmd == 3'h6)
                do_bit = w[19 + nab - cnt];
            else
                do_bit = ~do_bit;
        end
    end

    always @(negedge sclk)
    begin
        if (cs === 1'b1 && $realtime - t_rise < 250)
            viol = 1'b1;
    end
endmodule : sra_rom_model

// >>> src/sra_autoload.sv
// autoload sequencer: reads rom words 0..3 once after reset release
// runs entirely on the link clock; inputs are already synchronised
`timescale 1ns/10ps
module sra_autoload
    import sra_pkg::*;
(
    input  wire logic        clk_link,
    input  wire logic        link_rst,
    input  wire logic        start,
    input  wire logic        size_small,
    input  wire logic        do_bit,
    output sra_pins_t        seq_pins,
    output logic             busy,
    output logic             done,
    output logic [47:0]      station_address,
    output sra_cfg_t         config_a_byte
);

    sra_al_state_t state;
    logic [1:0]    word;
    logic [4:0]    bit_cnt;
    logic [1:0]    ph;
    logic [3:0]    tick;
    logic [10:0]   shreg;
    logic [14:0]   shin;
    logic [4:0]    nout;
    logic [4:0]    nlast;
    logic          tick_end;
    logic [15:0]   next_word;

    assign nout      = size_small ? 5'(SRA_CMD_BITS + SRA_ADDR_SMALL)
                                  : 5'(SRA_CMD_BITS + SRA_ADDR_LARGE);
    assign nlast     = 5'(nout + 5'(SRA_DATA_BITS - 1));
    assign tick_end  = (tick == 4'(SRA_PHASE_CYC - 1));
    assign next_word = {shin, do_bit};

    always_ff @(posedge clk_link)
    begin
        if (link_rst || tick_end || state == AL_IDLE)
            tick <= 4'h0;
        else
            tick <= 4'(tick + 4'h1);
    end

    always_ff @(posedge clk_link)
    begin
        if (link_rst)
        begin
            state    <= AL_IDLE;
            word     <= 2'h0;
            bit_cnt  <= 5'h00;
            ph       <= 2'h0;
            shreg    <= 11'h000;
            shin     <= 15'h0000;
            seq_pins <= '0;
            busy     <= 1'b0;
            done     <= 1'b0;
            station_address <= 48'h000000000000;
            config_a_byte   <= '0;
        end
        else
        begin
            case (state)
                AL_IDLE:
                    if (start)
                    begin
                        state <= AL_SELECT;
                        busy  <= 1'b1;
                        word  <= 2'h0;
                    end
                AL_SELECT:
                begin
                    seq_pins.cs <= 1'b1;
                    bit_cnt     <= 5'h00;
                    ph          <= 2'h0;
                    // command then word address, sent msb first
                    shreg <= size_small ? {SRA_CMD_READ, 6'(word), 2'h0}
                                        : {SRA_CMD_READ, 8'(word)};
                    if (tick_end)
                        state <= AL_SHIFT;
                end
                AL_SHIFT:
                begin
                    seq_pins.di   <= (bit_cnt < nout) ? shreg[10] : 1'b0;
                    // clock rises with the phase change so the synced rom data
                    // has settled by the sample at the end of the third phase
                    seq_pins.sclk <= tick_end ? (ph == 2'h0) : (ph == 2'h1);
                    if (tick_end)
                    begin
                        if (ph != 2'h2)
                            ph <= 2'(ph + 2'h1);
                        else
                        begin
                            ph    <= 2'h0;
                            shreg <= {shreg[9:0], 1'b0};
                            if (bit_cnt >= nout)
                                shin <= next_word[14:0];
                            if (bit_cnt == nlast)
                            begin
                                state <= AL_DESELECT;
                                if (word != SRA_LAST_WORD)
                                    station_address[16*word +: 16] <= next_word;
                                else
                                    config_a_byte <= sra_cfg_t'(next_word[6:0]);
                            end
                            else
                                bit_cnt <= 5'(bit_cnt + 5'h01);
                        end
                    end
                end
                AL_DESELECT:
                begin
                    seq_pins <= '0;
                    if (tick_end)
                    begin
                        if (word == SRA_LAST_WORD)
                        begin
                            state <= AL_DONE;
                            busy  <= 1'b0;
                            done  <= 1'b1;
                        end
                        else
                        begin
                            word  <= 2'(word + 2'h1);
                            state <= AL_SELECT;
                        end
                    end
                end
                AL_DONE:
                    state <= AL_DONE;
                default:
                    state <= AL_IDLE;
            endcase
        end
    end

    once_only_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        done |=> (done && !busy && state == AL_DONE))
        else $error("autoload ran again after completion");

    cfg_frozen_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        done |=> ($stable(config_a_byte) && $stable(station_address)))
        else $error("loaded values changed after autoload");

endmodule : sra_autoload

// >>> src/sra_top.sv
// serial rom access block: apb control register, pin drivers and autoload
// assumes apb on clk_sys and a free running clk_link for the rom pins
`timescale 1ns/10ps

// Operation
// - control bit 3 reads rom data out
// - control bit 2 drives rom data in
// - control bit 1 drives serial clock directly
// - control bit 0 drives chip select
// - pins follow register only while enable set
// - autoload runs once after reset rises
// - station address from locations 00h to 05h
// - config byte from location 06h
// - locations 07h onward not interpreted
module sra_top
    import sra_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        clk_link,
    input  wire logic        hardware_reset_pin,
    input  wire logic        rom_size_select,
    input  wire logic        rom_data_out,
    output logic             rom_chip_select,
    output logic             rom_serial_clock,
    output logic             rom_data_in,
    output logic [47:0]      station_address,
    output sra_cfg_t         config_a_byte,
    output logic             autoload_done
);

    // system clock domain
    logic [7:0]  ctrl;
    logic        req_tgl;
    logic        wr_pend;
    logic        ack_s1;
    logic        ack_s2;
    logic        do_s1;
    logic        do_s2;
    logic        busy_s1;
    logic        busy_s2;
    logic        done_s1;
    logic        done_s2;
    logic        done_s3;
    logic        access;
    logic        ctrl_hit;
    logic [31:0] next_rdata;
    logic        next_err;

    // link clock domain
    logic        hwr_s1;
    logic        hwr_s2;
    logic        hwr_s3;
    logic        link_rst;
    logic        al_start;
    logic        req_l1;
    logic        req_l2;
    logic        ack_l;
    logic [7:0]  ctrl_link;
    logic        size_l1;
    logic        size_l2;
    logic        do_l1;
    logic        do_l2;
    sra_pins_t   seq_pins;
    logic        al_busy;
    logic        al_done;
    logic [47:0] al_addr;
    sra_cfg_t    al_cfg;

    assign access   = psel && penable && !pready;
    assign ctrl_hit = (paddr == SRA_CTRL_OFF);

    // ---------------- system domain synchronisers ----------------
    always_ff @(posedge clk_sys)
    begin
        ack_s1  <= ack_l;
        ack_s2  <= ack_s1;
        do_s1   <= rom_data_out;
        do_s2   <= do_s1;
        busy_s1 <= al_busy;
        busy_s2 <= busy_s1;
        done_s1 <= al_done;
        done_s2 <= done_s1;
        done_s3 <= done_s2;
    end

    // ---------------- register read mux ----------------
    always_comb
    begin
        next_rdata = 32'h00000000;
        next_err   = 1'b0;
        case (paddr)
            SRA_CTRL_OFF:
            begin
                next_rdata[SRA_EN_BIT:0] = ctrl[SRA_EN_BIT:0];
                next_rdata[SRA_DO_BIT]   = do_s2;
            end
            SRA_STAT_OFF:
                next_rdata[1:0] = {done_s2, busy_s2};
            SRA_ADDR_LO_OFF:
                next_rdata = station_address[31:0];
            SRA_ADDR_HI_OFF:
                next_rdata = {9'h000, config_a_byte, station_address[47:32]};
            default:
                next_err = 1'b1;
        endcase
    end

    // ---------------- apb slave ----------------
    // a control write is answered only after the link side has taken it,
    // so back to back writes reach the pins in order and never tear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
            ctrl    <= SRA_CTRL_RST;
            req_tgl <= 1'b0;
            wr_pend <= 1'b0;
        end
        else
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            if (access)
            begin
                if (pwrite && ctrl_hit)
                begin
                    if (!wr_pend)
                    begin
                        ctrl    <= pwdata[7:0] & SRA_CTRL_WMSK;
                        req_tgl <= ~req_tgl;
                        wr_pend <= 1'b1;
                    end
                    else if (ack_s2 == req_tgl)
                    begin
                        wr_pend <= 1'b0;
                        pready  <= 1'b1;
                        prdata  <= 32'h00000000;
                    end
                end
                else
                begin
                    pready  <= 1'b1;
                    pslverr <= next_err;
                    prdata  <= pwrite ? 32'h00000000 : next_rdata;
                end
            end
        end
    end

    // ---------------- autoload results into system domain ----------------
    // link side holds the values steady once done is raised
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            station_address <= 48'h000000000000;
            config_a_byte   <= '0;
            autoload_done   <= 1'b0;
        end
        else
        begin
            autoload_done <= done_s2;
            if (done_s2 && !done_s3)
            begin
                station_address <= al_addr;
                config_a_byte   <= al_cfg;
            end
        end
    end

    // ---------------- link domain synchronisers ----------------
    always_ff @(posedge clk_link)
    begin
        hwr_s1  <= hardware_reset_pin;
        hwr_s2  <= hwr_s1;
        hwr_s3  <= hwr_s2;
        req_l1  <= req_tgl;
        req_l2  <= req_l1;
        size_l1 <= rom_size_select;
        size_l2 <= size_l1;
        do_l1   <= rom_data_out;
        do_l2   <= do_l1;
    end

    // link logic is held while the reset pin is low; its rise starts autoload
    assign link_rst = !hwr_s2;
    assign al_start = hwr_s2 && !hwr_s3;

    // ---------------- control word capture on the link ----------------
    always_ff @(posedge clk_link)
    begin
        if (link_rst)
        begin
            ack_l     <= 1'b0;
            ctrl_link <= SRA_CTRL_RST;
        end
        else if (req_l2 != ack_l)
        begin
            ctrl_link <= ctrl;
            ack_l     <= req_l2;
        end
    end

    // ---------------- pin drivers ----------------
    always_ff @(posedge clk_link)
    begin
        if (link_rst)
        begin
            rom_chip_select  <= 1'b0;
            rom_serial_clock <= 1'b0;
            rom_data_in      <= 1'b0;
        end
        else if (al_busy)
        begin
            rom_chip_select  <= seq_pins.cs;
            rom_serial_clock <= seq_pins.sclk;
            rom_data_in      <= seq_pins.di;
        end
        else if (ctrl_link[SRA_EN_BIT])
        begin
            rom_chip_select  <= ctrl_link[SRA_CS_BIT];
            rom_serial_clock <= ctrl_link[SRA_CLK_BIT];
            rom_data_in      <= ctrl_link[SRA_DI_BIT];
        end
        else
        begin
            rom_chip_select  <= 1'b0;
            rom_serial_clock <= 1'b0;
            rom_data_in      <= 1'b0;
        end
    end

    sra_autoload u_autoload (
        .clk_link        (clk_link),
        .link_rst        (link_rst),
        .start           (al_start),
        .size_small      (size_l2),
        .do_bit          (do_l2),
        .seq_pins        (seq_pins),
        .busy            (al_busy),
        .done            (al_done),
        .station_address (al_addr),
        .config_a_byte   (al_cfg)
    );

    // ---------------- checks ----------------
    sequence ctrl_wr_start_s;
        access && pwrite && ctrl_hit && !wr_pend;
    endsequence

    sequence ctrl_wr_wait_s;
        (!pready && wr_pend) [*4];
    endsequence

    ctrl_write_ack_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        ctrl_wr_start_s |=> ctrl_wr_wait_s ##[1:400] (pready && !wr_pend))
        else $error("control write not answered after link handshake");

    rd_bit3_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (access && !pwrite && ctrl_hit)
            |=> (pready && prdata[SRA_DO_BIT] == $past(do_s2)))
        else $error("control bit 3 does not show rom data out");

    capture_addr_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (done_s2 && !done_s3) |=> (station_address == al_addr))
        else $error("station address not taken from autoload");

    capture_cfg_a: assert property (
        @(posedge clk_sys) disable iff (rst)
        (done_s2 && !done_s3) |=> (config_a_byte == al_cfg))
        else $error("config byte not taken from autoload");

    pin_data_in_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        (!al_busy && ctrl_link[SRA_EN_BIT]) |=> (rom_data_in == $past(ctrl_link[SRA_DI_BIT])))
        else $error("rom data in does not follow control bit 2");

    pin_clock_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        (!al_busy && ctrl_link[SRA_EN_BIT] && $changed(ctrl_link[SRA_CLK_BIT]))
            |=> (rom_serial_clock == $past(ctrl_link[SRA_CLK_BIT])))
        else $error("serial clock does not follow control bit 1");

    pin_select_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        (!al_busy && ctrl_link[SRA_EN_BIT]) |=> (rom_chip_select == $past(ctrl_link[SRA_CS_BIT])))
        else $error("chip select does not follow control bit 0");

    soft_gate_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        (!al_busy && !ctrl_link[SRA_EN_BIT])
            |=> !(rom_chip_select || rom_serial_clock || rom_data_in))
        else $error("rom pins driven while access disabled");

    seq_owns_a: assert property (
        @(posedge clk_link) disable iff (link_rst)
        al_busy |=> (rom_chip_select == $past(seq_pins.cs)
                     && rom_serial_clock == $past(seq_pins.sclk)))
        else $error("software reached the pins during autoload");

endmodule : sra_top
